// *** verilog/serfmt_cfg.svh ***
`ifndef SERFMT_CFG_SVH
`define SERFMT_CFG_SVH
`define SF_ADDR_W 8
`define SF_ADDR_STATUS 8'h00
`define SF_ADDR_MASK 8'h04
`define SF_ADDR_CONTROL 8'h08
`define SF_ADDR_STATE 8'h0c
`define SF_IRQ_PAT 0
`define SF_IRQ_FIFO 1
`define SF_CTL_REINIT 0
`define SF_CTL_REARM 1
`define SF_RESP_OKAY 2'b00
`define SF_RESP_SLVERR 2'b10
`define SF_PRBS_ORDER 7
`define SF_PRBS_TAP 6
`define SF_REINIT_CYCLES 4
`define SF_WORD_W 20
`define SF_LANE_W 10
`endif

// *** verilog/serfmt_pkg.sv ***
package serfmt_pkg;
  typedef enum logic [1:0] {
    SERFMT_FMT_RAW = 2'b00,
    SERFMT_FMT_ETH = 2'b01,
    SERFMT_FMT_FC = 2'b10,
    SERFMT_FMT_PLAIN = 2'b11
  } serfmt_fmt_t;
  typedef enum logic [1:0] {
    SERFMT_ST_RUN = 2'b00,
    SERFMT_ST_REINIT = 2'b01
  } serfmt_fifo_st_t;
endpackage

// *** verilog/serfmt_status.sv ***
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`include "serfmt_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module serfmt_status
  import serfmt_pkg::*;
#(
  parameter int WORD_W = `SF_WORD_W,
  parameter int REINIT_CYCLES = `SF_REINIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic pattern_test_enable_in,
  input wire logic comma_align_enable_in,
  input wire logic tx_format_sel0_in,
  input wire logic tx_format_sel1_in,
  input wire logic rx_decode_select_in,
  input wire logic rx_rate_select_in,
  input wire logic [WORD_W-1:0] rx_word_in,
  input wire logic rx_word_valid_in,
  input wire logic tx_fifo_overflow_in,
  input wire logic tx_fifo_underflow_in,
  output logic pattern_check_pass_out,
  output logic tx_fifo_reinit_out,
  output logic tx_encoder_bypass_out,
  output logic tx_idle_preserve_out,
  output logic tx_eof_preserve_out,
  output logic rx_decoder_bypass_out,
  output logic comma_search_out,
  output logic rx_two_byte_out,
  output logic irq_out,
  input wire logic [`SF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SF_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int EXT_W = WORD_W + `SF_PRBS_ORDER;
  localparam int CNT_W = $clog2(REINIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REINIT_CYCLES - 1);

  generate
    if (WORD_W != 2 * `SF_LANE_W || REINIT_CYCLES < 1) begin : g_bad
      $error("serfmt_status: unsupported parameters");
    end
  endgenerate

  // pins are asynchronous to clk_in; meta stage feeds only the next stage
  logic [5:0] pin_meta_reg, pin_sync_reg;
  logic align_d_reg;
  always_ff @(posedge clk_in) begin
    pin_meta_reg <= {pattern_test_enable_in, comma_align_enable_in,
                     tx_format_sel0_in, tx_format_sel1_in,
                     rx_decode_select_in, rx_rate_select_in};
    pin_sync_reg <= pin_meta_reg;
    align_d_reg <= pin_sync_reg[4];
  end
  wire pat_en = pin_sync_reg[5];
  wire align_en = pin_sync_reg[4];
  wire serfmt_fmt_t fmt = serfmt_fmt_t'(pin_sync_reg[3:2]);
  wire rx_decode = pin_sync_reg[1];
  wire two_byte = pin_sync_reg[0];
  wire align_toggle = align_en ^ align_d_reg;

  // self-synchronising pattern check, bit 0 oldest in time
  logic [`SF_PRBS_ORDER-1:0] hist_reg;
  wire [EXT_W-1:0] ext = {rx_word_in, hist_reg};
  wire [WORD_W-1:0] bit_miss;
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_chk
      localparam int J = gi + `SF_PRBS_ORDER;
      assign bit_miss[gi] = ext[J] ^ ext[J-`SF_PRBS_ORDER]
                            ^ ext[J-`SF_PRBS_ORDER+`SF_PRBS_TAP];
    end
  endgenerate
  // upper lane checked only in two-byte mode, after the lower one
  wire [WORD_W-1:0] lane_mask = two_byte ? {WORD_W{1'b1}} :
                    {{(WORD_W-`SF_LANE_W){1'b0}}, {`SF_LANE_W{1'b1}}};
  wire err_now = rx_word_valid_in & (|(bit_miss & lane_mask));
  wire [`SF_PRBS_ORDER-1:0] hist_next = !rx_word_valid_in ? hist_reg :
    two_byte ? ext[EXT_W-1 -: `SF_PRBS_ORDER] :
    ext[`SF_LANE_W+`SF_PRBS_ORDER-1 -: `SF_PRBS_ORDER];

  logic seen_reg, fail_latched_reg, sw_rearm_reg;
  wire latched_mode = align_en;
  wire rearm = align_toggle | sw_rearm_reg;
  // a fresh mismatch beats a re-arm in the same cycle
  wire fail_latched_next = (pat_en & latched_mode & err_now) |
                           (fail_latched_reg & !rearm);
  wire seen_next = seen_reg | rx_word_valid_in;
  wire pass_next = seen_next & !err_now &
                   !(latched_mode & fail_latched_reg);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hist_reg <= '0;
      seen_reg <= 1'b0;
      fail_latched_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      seen_reg <= seen_next;
      fail_latched_reg <= fail_latched_next;
    end
  end

  // fifo reinit sequencer; reset itself starts a reinit
  serfmt_fifo_st_t fifo_st_reg, fifo_st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic fifo_err_reg, force_reinit_reg;
  wire fifo_event = tx_fifo_overflow_in | tx_fifo_underflow_in;
  wire reinit_done = (fifo_st_reg == SERFMT_ST_REINIT) &&
                     (cnt_reg == CNT_LAST);
  always_comb begin
    fifo_st_next = fifo_st_reg;
    cnt_next = cnt_reg;
    case (fifo_st_reg)
      SERFMT_ST_RUN: begin
        cnt_next = '0;
        if (fifo_event || force_reinit_reg) begin
          fifo_st_next = SERFMT_ST_REINIT;
        end
      end
      SERFMT_ST_REINIT: begin
        if (fifo_event) begin
          cnt_next = '0;
        end else if (reinit_done) begin
          fifo_st_next = SERFMT_ST_RUN;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        fifo_st_next = SERFMT_ST_REINIT;
        cnt_next = '0;
      end
    endcase
  end
  wire fifo_err_next = fifo_event | (fifo_err_reg & !reinit_done);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fifo_st_reg <= SERFMT_ST_REINIT;
      cnt_reg <= '0;
      fifo_err_reg <= 1'b0;
      tx_fifo_reinit_out <= 1'b1;
    end else begin
      fifo_st_reg <= fifo_st_next;
      cnt_reg <= cnt_next;
      fifo_err_reg <= fifo_err_next;
      tx_fifo_reinit_out <= (fifo_st_next == SERFMT_ST_REINIT);
    end
  end

  // shared pin and format outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pattern_check_pass_out <= 1'b0;
      tx_encoder_bypass_out <= 1'b1;
      tx_idle_preserve_out <= 1'b0;
      tx_eof_preserve_out <= 1'b0;
      rx_decoder_bypass_out <= 1'b1;
      comma_search_out <= 1'b0;
      rx_two_byte_out <= 1'b0;
    end else begin
      pattern_check_pass_out <= pat_en ? pass_next : fifo_err_next;
      tx_encoder_bypass_out <= (fmt == SERFMT_FMT_RAW);
      tx_idle_preserve_out <= (fmt == SERFMT_FMT_ETH);
      tx_eof_preserve_out <= (fmt == SERFMT_FMT_FC);
      rx_decoder_bypass_out <= !rx_decode;
      // align input means latch mode while the pattern test runs
      comma_search_out <= align_en & !pat_en;
      rx_two_byte_out <= two_byte;
    end
  end

  // register file and interrupt
  logic [1:0] irq_stat_reg, irq_mask_reg;
  logic aw_full_reg, w_full_reg;
  logic [`SF_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_full_reg & w_full_reg & !s_axi_bvalid;
  wire wr_en = do_write & wstrb0_reg;
  wire wr_stat = wr_en && (awaddr_reg == `SF_ADDR_STATUS);
  wire wr_mask = wr_en && (awaddr_reg == `SF_ADDR_MASK);
  wire wr_ctl = wr_en && (awaddr_reg == `SF_ADDR_CONTROL);
  wire wr_map = (awaddr_reg == `SF_ADDR_STATUS) ||
                (awaddr_reg == `SF_ADDR_MASK) ||
                (awaddr_reg == `SF_ADDR_CONTROL);
  wire [1:0] irq_set = {fifo_event, pat_en & err_now};
  wire [1:0] irq_clr = wr_stat ? wdata_reg[1:0] : 2'b00;
  // hardware set wins over a write-one clear in the same cycle
  wire [1:0] irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
  wire [1:0] irq_mask_next = wr_mask ? wdata_reg[1:0] : irq_mask_reg;
  wire aw_full_next = (aw_full_reg | aw_hs) & !do_write;
  wire w_full_next = (w_full_reg | w_hs) & !do_write;
  wire bvalid_next = do_write | (s_axi_bvalid & !s_axi_bready);
  wire rvalid_next = ar_hs | (s_axi_rvalid & !s_axi_rready);
  wire [31:0] state_word = {25'h0000000, fail_latched_reg, fifo_err_reg,
                            tx_fifo_reinit_out, pat_en, rx_decode, fmt};
  wire ar_map = (s_axi_araddr == `SF_ADDR_STATUS) ||
                (s_axi_araddr == `SF_ADDR_MASK) ||
                (s_axi_araddr == `SF_ADDR_CONTROL) ||
                (s_axi_araddr == `SF_ADDR_STATE);
  wire [31:0] rd_word =
    (s_axi_araddr == `SF_ADDR_STATUS) ? {30'h00000000, irq_stat_reg} :
    (s_axi_araddr == `SF_ADDR_MASK) ? {30'h00000000, irq_mask_reg} :
    (s_axi_araddr == `SF_ADDR_STATE) ? state_word : 32'h00000000;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      force_reinit_reg <= 1'b0;
      sw_rearm_reg <= 1'b0;
      irq_out <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SF_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SF_RESP_OKAY;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      // control bits are self-clearing strobes
      force_reinit_reg <= wr_ctl & wdata_reg[`SF_CTL_REINIT];
      sw_rearm_reg <= wr_ctl & wdata_reg[`SF_CTL_REARM];
      irq_out <= |(irq_stat_next & irq_mask_next);
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_hs) awaddr_reg <= s_axi_awaddr;
      if (w_hs) wdata_reg <= s_axi_wdata;
      if (w_hs) wstrb0_reg <= s_axi_wstrb[0];
      s_axi_awready <= !aw_full_next & !bvalid_next;
      s_axi_wready <= !w_full_next & !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) s_axi_bresp <= wr_map ? `SF_RESP_OKAY : `SF_RESP_SLVERR;
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_hs) s_axi_rdata <= rd_word;
      if (ar_hs) s_axi_rresp <= ar_map ? `SF_RESP_OKAY : `SF_RESP_SLVERR;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_unl_err;
    pat_en && !latched_mode && err_now;
  endsequence
  sequence s_lat_err;
    pat_en && latched_mode && err_now;
  endsequence
  sequence s_no_rearm;
    (pat_en && latched_mode && !rearm)[*3];
  endsequence
  chk_mux_fifo: assert property (!pat_en |=>
    pattern_check_pass_out == fifo_err_reg)
    else $error("status pin not showing fifo error");
  chk_pass_match: assert property (pat_en && seen_reg &&
    rx_word_valid_in && !err_now && !fail_latched_reg |=>
    pattern_check_pass_out)
    else $error("pass flag low on matching word");
  chk_unl_pulse: assert property (s_unl_err ##1
    (pat_en && !latched_mode && rx_word_valid_in && !err_now) |=>
    !$past(pattern_check_pass_out) && pattern_check_pass_out)
    else $error("unlatched pass low not one cycle");
  chk_latch_hold: assert property (s_lat_err ##1 s_no_rearm |=>
    !pattern_check_pass_out)
    else $error("latched pass flag released");
  chk_toggle_rearm: assert property (fail_latched_reg && align_toggle
    && !err_now |=> !fail_latched_reg)
    else $error("toggle did not re-arm");
  chk_fifo_err_hold: assert property (fifo_event |=> fifo_err_reg
    ##[1:64] !fifo_err_reg)
    else $error("fifo error not held or never cleared");
  chk_fifo_reinit: assert property (fifo_event |=>
    tx_fifo_reinit_out && fifo_st_reg == SERFMT_ST_REINIT)
    else $error("fifo not reinitialising after error");
  chk_tx_bypass: assert property ($stable(fmt) |=>
    tx_encoder_bypass_out == ($past(fmt) == SERFMT_FMT_RAW))
    else $error("encoder bypass wrong for format");
  chk_rx_bypass: assert property ($stable(rx_decode) |=>
    rx_decoder_bypass_out != $past(rx_decode))
    else $error("decoder bypass wrong");
endmodule
`default_nettype wire

// *** bench/serfmt_mac_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module serfmt_mac_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic inject_in,
  output logic [19:0] word_out,
  output logic valid_out
);
  logic [6:0] hist_reg;
  logic [6:0] hist_next;
  logic [19:0] word_next;
  always_comb begin
    hist_next = hist_reg;
    for (int i = 0; i < 20; i++) begin
      // taps one and seven bits back, matching the block's checker
      word_next[i] = hist_next[0] ^ hist_next[6];
      hist_next = {hist_next[5:0], word_next[i]};
    end
  end
  // flip bit0 only: self-synced check then fails in this word alone
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hist_reg <= 7'h7f;
      word_out <= 20'h00000;
      valid_out <= 1'b0;
    end else if (run_in) begin
      hist_reg <= hist_next;
      word_out <= word_next ^ {19'h00000, inject_in};
      valid_out <= 1'b1;
    end else begin
      // idle bus inverts each cycle, so the last word comes back every second idle cycle
      word_out <= ~word_out;
      valid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_serdes_format_and_prbs_status.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_serdes_format_and_prbs_status;
  import serfmt_pkg::*;
  logic clk_in, sys_rst_in, pte, cae, s0, s1, dec, rate, ovf, unf;
  logic run, inj, rxv, pass, reinit, ebyp, idle, eof, dbyp, cs, two, irq;
  logic [19:0] rxw;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_fail, checks, cycles, lows;
  logic [4:0] row_in [4] = '{5'b00000, 5'b01111, 5'b10010, 5'b11101};
  logic [5:0] row_exp [4] = '{6'b100100, 6'b010011, 6'b001110, 6'b000001};
  serfmt_status DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .pattern_test_enable_in(pte), .comma_align_enable_in(cae),
    .tx_format_sel0_in(s0), .tx_format_sel1_in(s1),
    .rx_decode_select_in(dec), .rx_rate_select_in(rate),
    .rx_word_in(rxw), .rx_word_valid_in(rxv),
    .tx_fifo_overflow_in(ovf), .tx_fifo_underflow_in(unf),
    .pattern_check_pass_out(pass), .tx_fifo_reinit_out(reinit),
    .tx_encoder_bypass_out(ebyp), .tx_idle_preserve_out(idle),
    .tx_eof_preserve_out(eof), .rx_decoder_bypass_out(dbyp),
    .comma_search_out(cs), .rx_two_byte_out(two), .irq_out(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  serfmt_mac_model mac (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .run_in(run), .inject_in(inj), .word_out(rxw), .valid_out(rxv));
  // one clock only: tx clock taken as locked to the reference
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) aw_ok = 1;
      if (wvalid && wready) w_ok = 1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask
  task automatic count_low(input int n);
    lows = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (pass !== 1'b1) lows++;
    end
  endtask
  task automatic pulse_inj();
    @(posedge clk_in);
    inj <= 1'b1;
    @(posedge clk_in);
    inj <= 1'b0;
  endtask
  initial begin
    {pte, cae, s0, s1, dec, rate, ovf, unf, run, inj} = 10'h000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    sys_rst_in = 1'b1;
    n_fail = 0;
    checks = 0;
    cycles = 0;
    tick(3);
    check("status in reset", 1'b0, pass);
    check("reinit in reset", 1'b1, reinit);
    repeat (13) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    tick(8);
    check("reinit after reset", 1'b0, reinit);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      {s0, s1, dec, rate, cae} <= row_in[i];
      tick(4);
      check("tx mode", row_exp[i][5:3], {ebyp, idle, eof});
      check("rx mode", row_exp[i][2:0], {dbyp, two, cs});
    end
    @(posedge clk_in);
    {s0, s1, dec, rate, cae} <= 5'b00010;
    axi_wr(8'h04, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      ovf <= (k == 0);
      unf <= (k == 1);
      @(posedge clk_in);
      ovf <= 1'b0;
      unf <= 1'b0;
      tick(1);
      check("fifo err", 2'b11, {pass, reinit});
      tick(8);
      check("fifo err end", 2'b00, {pass, reinit});
    end
    check("irq masked", 1'b0, irq);
    axi_wr(8'h04, 32'h2);
    tick(3);
    check("irq unmasked", 1'b1, irq);
    axi_rd(8'h00);
    check("status reg", 32'h2, rd);
    axi_rd(8'h04);
    check("mask reg", 32'h2, rd);
    axi_wr(8'h00, 32'h2);
    tick(3);
    check("irq cleared", 1'b0, irq);
    axi_rd(8'h10);
    check("unmapped rresp", 2'b10, rsp);
    check("unmapped rd", 32'h0, rd);
    axi_wr(8'h20, 32'h1);
    check("unmapped wr", 2'b10, rsp);
    @(posedge clk_in);
    run <= 1'b1;
    pte <= 1'b1;
    tick(30);
    check("pass good", 2'b10, {pass, cs});
    pulse_inj();
    count_low(12);
    check("unlatched lows", 1, lows);
    @(posedge clk_in);
    cae <= 1'b1;
    tick(6);
    check("latched armed", 1'b1, pass);
    pulse_inj();
    @(posedge clk_in);
    ovf <= 1'b1;
    @(posedge clk_in);
    ovf <= 1'b0;
    count_low(12);
    check("latched lows", 12, lows);
    @(posedge clk_in);
    cae <= 1'b0;
    repeat (5) @(posedge clk_in);
    cae <= 1'b1;
    tick(6);
    check("toggle clears", 1'b1, pass);
    pulse_inj();
    tick(5);
    check("latched again", 1'b0, pass);
    axi_wr(8'h08, 32'h2);
    tick(3);
    check("rearm clears", 1'b1, pass);
    axi_rd(8'h00);
    check("status both", 32'h3, rd);
    @(posedge clk_in);
    pte <= 1'b0;
    tick(6);
    check("test off", 2'b01, {pass, cs});
    // forced reinit must not raise the fifo error
    axi_wr(8'h08, 32'h1);
    tick(1);
    check("forced reinit", 2'b01, {pass, reinit});
    tick(8);
    check("forced reinit end", 2'b00, {pass, reinit});
    // second reset mid-run, test on but no words arriving
    @(posedge clk_in);
    run <= 1'b0;
    pte <= 1'b1;
    sys_rst_in <= 1'b1;
    tick(4);
    check("reset again", 2'b01, {pass, reinit});
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    tick(8);
    check("no word yet", 2'b00, {pass, reinit});
    conclude();
  end
endmodule
`default_nettype wire
